// ---- acl_pkg.sv ----
// Shared constants, encodings and helpers for the access rule entry matcher
package acl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ARP_CFG = 8'h04;
    localparam logic [7:0] OFF_IP_CFG = 8'h08;
    localparam logic [7:0] OFF_ADDR_CFG = 8'h0C;
    localparam logic [7:0] OFF_SRC_ADDR = 8'h10;
    localparam logic [7:0] OFF_SRC_MASK = 8'h14;
    localparam logic [7:0] OFF_DST_ADDR = 8'h18;
    localparam logic [7:0] OFF_DST_MASK = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_HIT_COUNT = 8'h24;
    localparam logic [7:0] OFF_FRAME_COUNT = 8'h28;
    // Writable bits of the control, ARP, IP and address-mode configuration registers
    localparam logic [31:0] MASK_CTRL = 32'h0000_0001;
    localparam logic [31:0] MASK_ARP_CFG = 32'h0000_003F;
    localparam logic [31:0] MASK_IP_CFG = 32'h003F_FF07;
    localparam logic [31:0] MASK_ADDR_CFG = 32'h0000_000F;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Field positions
    localparam int ARP_LEN_LSB = 0;
    localparam int ARP_HW_LSB = 2;
    localparam int ARP_PRO_LSB = 4;
    localparam int IP_SEL_LSB = 0;
    localparam int IP_VAL_LSB = 8;
    localparam int IP_TTL_LSB = 16;
    localparam int IP_FRAG_LSB = 18;
    localparam int IP_OPT_LSB = 20;
    localparam int SRC_MODE_LSB = 0;
    localparam int DST_MODE_LSB = 2;
    // Three-way criterion: don't-care, condition false (0/No/zero), condition true
    localparam logic [1:0] TRI_ANY = 2'h0;
    localparam logic [1:0] TRI_FALSE = 2'h1;
    localparam logic [1:0] TRI_TRUE = 2'h2;
    // Protocol selector codes and transport numbers
    localparam logic [2:0] PSEL_ANY = 3'h0;
    localparam logic [2:0] PSEL_SPECIFIC = 3'h1;
    localparam logic [2:0] PSEL_ICMP = 3'h2;
    localparam logic [2:0] PSEL_UDP = 3'h3;
    localparam logic [2:0] PSEL_TCP = 3'h4;
    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    // Address filter modes
    localparam logic [1:0] AMODE_ANY = 2'h0;
    localparam logic [1:0] AMODE_HOST = 2'h1;
    localparam logic [1:0] AMODE_NET = 2'h2;
    // ARP header reference values
    localparam logic [7:0] ARP_HLEN_ETH = 8'h06;
    localparam logic [7:0] ARP_PLEN_IPV4 = 8'h04;
    localparam logic [15:0] ARP_HTYPE_ETH = 16'h0001;
    localparam logic [15:0] ARP_PTYPE_IP = 16'h0800;
    // Per-criterion result vector layout
    localparam int CRIT_W = 9;

    // Evaluate a three-way criterion against a frame condition
    function automatic logic triMatch(input logic [1:0] sel, input logic cond);
        case (sel)
            TRI_FALSE: triMatch = !cond;
            TRI_TRUE: triMatch = cond;
            default: triMatch = 1'b1;
        endcase
    endfunction : triMatch

    // Merge write data into a register under byte strobes and a writable mask
    function automatic logic [31:0] strbWrite(input logic [31:0] old, input logic [31:0] wdata,
        input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        strbWrite = (old & ~bm) | (wdata & bm);
    endfunction : strbWrite
endpackage : acl_pkg

// ---- frame_hdr_if.sv ----
// Header fields of one received frame, passed from the top to the checker
`timescale 1ns/1ps
interface frame_hdr_if;
    logic isIpv4;
    logic isArp;
    logic [7:0] arpHwLen;
    logic [7:0] arpProtoLen;
    logic [15:0] arpHwType;
    logic [15:0] arpProtoType;
    logic [7:0] ipProto;
    logic [7:0] ipTtl;
    logic moreFragments;
    logic [12:0] fragmentPosition;
    logic ipOptions;
    modport source (output isIpv4, isArp, arpHwLen, arpProtoLen, arpHwType, arpProtoType,
        ipProto, ipTtl, moreFragments, fragmentPosition, ipOptions);
    modport sink (input isIpv4, isArp, arpHwLen, arpProtoLen, arpHwType, arpProtoType,
        ipProto, ipTtl, moreFragments, fragmentPosition, ipOptions);
endinterface : frame_hdr_if

// ---- ipv4_addr_filter.sv ----
// IPv4 address filter with Any, Host and Network modes
`timescale 1ns/1ps
module ipv4_addr_filter
    import acl_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic [31:0] cfgAddr,
    input wire logic [31:0] cfgMask,
    input wire logic [31:0] frameAddr,
    input wire logic isIpv4,
    output logic match
);
    // Compare the frame address as the mode asks; non-IPv4 frames fail in Host and Network modes
    always_comb
    begin
        case (mode)
            AMODE_HOST: match = isIpv4 && (frameAddr == cfgAddr);
            AMODE_NET: match = isIpv4 && ((frameAddr & cfgMask) == (cfgAddr & cfgMask));
            default: match = 1'b1;
        endcase
    end
endmodule : ipv4_addr_filter

// ---- header_criteria_check.sv ----
// ARP and IPv4 header criteria of one access rule entry
`timescale 1ns/1ps
module header_criteria_check
    import acl_pkg::*;
(
    frame_hdr_if.sink hdr,
    input wire logic [31:0] arpCfg,
    input wire logic [31:0] ipCfg,
    output logic [6:0] critOk
);
    logic [1:0] lenSel;
    logic [1:0] hwSel;
    logic [1:0] proSel;
    logic [2:0] protoSel;
    logic [7:0] protoVal;
    logic [1:0] ttlSel;
    logic [1:0] fragSel;
    logic [1:0] optSel;
    logic protoHit;
    logic fragmented;

    // Unpack the configuration fields
    assign lenSel = arpCfg[ARP_LEN_LSB +: 2];
    assign hwSel = arpCfg[ARP_HW_LSB +: 2];
    assign proSel = arpCfg[ARP_PRO_LSB +: 2];
    assign protoSel = ipCfg[IP_SEL_LSB +: 3];
    assign protoVal = ipCfg[IP_VAL_LSB +: 8];
    assign ttlSel = ipCfg[IP_TTL_LSB +: 2];
    assign fragSel = ipCfg[IP_FRAG_LSB +: 2];
    assign optSel = ipCfg[IP_OPT_LSB +: 2];
    assign fragmented = hdr.moreFragments || (hdr.fragmentPosition != '0);

    // Protocol selector
    always_comb
    begin
        case (protoSel)
            PSEL_SPECIFIC: protoHit = hdr.ipProto == protoVal;
            PSEL_ICMP: protoHit = hdr.ipProto == PROTO_ICMP;
            PSEL_UDP: protoHit = hdr.ipProto == PROTO_UDP;
            PSEL_TCP: protoHit = hdr.ipProto == PROTO_TCP;
            default: protoHit = 1'b1;
        endcase
    end

    // Each criterion passes when don't-care or when the frame type fits and the field matches
    always_comb
    begin
        critOk[0] = (lenSel == TRI_ANY) || (hdr.isArp && triMatch(lenSel,
            (hdr.arpHwLen == ARP_HLEN_ETH) && (hdr.arpProtoLen == ARP_PLEN_IPV4)));
        critOk[1] = (hwSel == TRI_ANY)
            || (hdr.isArp && triMatch(hwSel, hdr.arpHwType == ARP_HTYPE_ETH));
        critOk[2] = (proSel == TRI_ANY)
            || (hdr.isArp && triMatch(proSel, hdr.arpProtoType == ARP_PTYPE_IP));
        critOk[3] = (protoSel == PSEL_ANY) || (hdr.isIpv4 && protoHit);
        critOk[4] = (ttlSel == TRI_ANY)
            || (hdr.isIpv4 && triMatch(ttlSel, hdr.ipTtl != '0));
        critOk[5] = (fragSel == TRI_ANY) || (hdr.isIpv4 && triMatch(fragSel, fragmented));
        critOk[6] = (optSel == TRI_ANY) || (hdr.isIpv4 && triMatch(optSel, hdr.ipOptions));
    end
endmodule : header_criteria_check

// ---- acl_frame_header_matcher.sv ----
// Access rule entry matcher: APB configuration, header checks and registered hit result
`timescale 1ns/1ps
module acl_frame_header_matcher
    import acl_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frameValid,
    input wire logic frameIsIpv4,
    input wire logic frameIsArp,
    input wire logic [7:0] arpHwLen,
    input wire logic [7:0] arpProtoLen,
    input wire logic [15:0] arpHwType,
    input wire logic [15:0] arpProtoType,
    input wire logic [7:0] ipProto,
    input wire logic [7:0] ipTtl,
    input wire logic moreFragments,
    input wire logic [12:0] fragmentPosition,
    input wire logic ipOptions,
    input wire logic [31:0] srcIp,
    input wire logic [31:0] dstIp,
    output logic hitValid,
    output logic entryHit
);
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_RESP = 2'b10
    } apb_state_e;

    apb_state_e apbState_reg;
    apb_state_e apbState_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] arpCfg_reg;
    logic [31:0] arpCfg_next;
    logic [31:0] ipCfg_reg;
    logic [31:0] ipCfg_next;
    logic [31:0] addrCfg_reg;
    logic [31:0] addrCfg_next;
    logic [31:0] srcAddr_reg;
    logic [31:0] srcAddr_next;
    logic [31:0] srcMask_reg;
    logic [31:0] srcMask_next;
    logic [31:0] dstAddr_reg;
    logic [31:0] dstAddr_next;
    logic [31:0] dstMask_reg;
    logic [31:0] dstMask_next;

    logic hitValid_reg;
    logic hitValid_next;
    logic entryHit_reg;
    logic entryHit_next;
    logic [CRIT_W-1:0] lastCrit_reg;
    logic [CRIT_W-1:0] lastCrit_next;
    logic [31:0] hitCount_reg;
    logic [31:0] hitCount_next;
    logic [31:0] frameCount_reg;
    logic [31:0] frameCount_next;

    logic [7:0] regAddr;
    logic addrMapped;
    logic readOnlyHit;
    logic accessNow;
    logic commitNow;
    logic [31:0] readValue;
    logic [6:0] hdrOk;
    logic srcOk;
    logic dstOk;
    logic [CRIT_W-1:0] critAll;
    logic allOk;

    frame_hdr_if hdrBus();

    // Drive the header carrier from the frame ports
    assign hdrBus.isIpv4 = frameIsIpv4;
    assign hdrBus.isArp = frameIsArp;
    assign hdrBus.arpHwLen = arpHwLen;
    assign hdrBus.arpProtoLen = arpProtoLen;
    assign hdrBus.arpHwType = arpHwType;
    assign hdrBus.arpProtoType = arpProtoType;
    assign hdrBus.ipProto = ipProto;
    assign hdrBus.ipTtl = ipTtl;
    assign hdrBus.moreFragments = moreFragments;
    assign hdrBus.fragmentPosition = fragmentPosition;
    assign hdrBus.ipOptions = ipOptions;

    // ARP and IPv4 header criteria
    header_criteria_check headerCheck (
        .hdr(hdrBus.sink),
        .arpCfg(arpCfg_reg),
        .ipCfg(ipCfg_reg),
        .critOk(hdrOk)
    );

    // Source address filter
    ipv4_addr_filter srcFilter (
        .mode(addrCfg_reg[SRC_MODE_LSB +: 2]),
        .cfgAddr(srcAddr_reg),
        .cfgMask(srcMask_reg),
        .frameAddr(srcIp),
        .isIpv4(frameIsIpv4),
        .match(srcOk)
    );

    // Destination address filter, same structure as the source side
    ipv4_addr_filter dstFilter (
        .mode(addrCfg_reg[DST_MODE_LSB +: 2]),
        .cfgAddr(dstAddr_reg),
        .cfgMask(dstMask_reg),
        .frameAddr(dstIp),
        .isIpv4(frameIsIpv4),
        .match(dstOk)
    );

    // Combine every criterion; the entry hits only if all pass
    assign critAll = {dstOk, srcOk, hdrOk};
    assign allOk = &critAll;

    // Address decode for the APB slave
    assign regAddr = 8'(paddr);
    assign accessNow = psel && penable;
    assign commitNow = accessNow && (apbState_reg == APB_RESP);
    always_comb
    begin
        addrMapped = 1'b1;
        readOnlyHit = 1'b0;
        readValue = RST_ZERO;
        case (regAddr)
            OFF_CTRL: readValue = ctrl_reg;
            OFF_ARP_CFG: readValue = arpCfg_reg;
            OFF_IP_CFG: readValue = ipCfg_reg;
            OFF_ADDR_CFG: readValue = addrCfg_reg;
            OFF_SRC_ADDR: readValue = srcAddr_reg;
            OFF_SRC_MASK: readValue = srcMask_reg;
            OFF_DST_ADDR: readValue = dstAddr_reg;
            OFF_DST_MASK: readValue = dstMask_reg;
            OFF_STATUS:
            begin
                readValue = {21'(0), lastCrit_reg, entryHit_reg, hitValid_reg};
                readOnlyHit = 1'b1;
            end
            OFF_HIT_COUNT: readValue = hitCount_reg;
            OFF_FRAME_COUNT: readValue = frameCount_reg;
            default: addrMapped = 1'b0;
        endcase
        if (ADDR_W > 8 && paddr != ADDR_W'(regAddr))
        begin
            addrMapped = 1'b0;
        end
    end

    // APB handshake: one wait state, then pready with data and error for one cycle
    always_comb
    begin
        apbState_next = apbState_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = RST_ZERO; // Read data shows only with pready
        case (apbState_reg)
            APB_IDLE:
            begin
                if (accessNow)
                begin
                    apbState_next = APB_RESP;
                    pready_next = 1'b1;
                    pslverr_next = !addrMapped || (pwrite && readOnlyHit);
                    prdata_next = (pwrite || !addrMapped) ? RST_ZERO : readValue;
                end
            end
            APB_RESP:
            begin
                apbState_next = APB_IDLE;
            end
            default:
            begin
                apbState_next = APB_IDLE;
            end
        endcase
    end

    // APB state registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            apbState_reg <= APB_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RST_ZERO;
        end
        else
        begin
            apbState_reg <= apbState_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // Configuration writes take effect at the edge where the master sees pready
    always_comb
    begin
        ctrl_next = ctrl_reg;
        arpCfg_next = arpCfg_reg;
        ipCfg_next = ipCfg_reg;
        addrCfg_next = addrCfg_reg;
        srcAddr_next = srcAddr_reg;
        srcMask_next = srcMask_reg;
        dstAddr_next = dstAddr_reg;
        dstMask_next = dstMask_reg;
        if (commitNow && pwrite)
        begin
            case (regAddr)
                OFF_CTRL: ctrl_next = strbWrite(ctrl_reg, pwdata, pstrb, MASK_CTRL);
                OFF_ARP_CFG: arpCfg_next = strbWrite(arpCfg_reg, pwdata, pstrb, MASK_ARP_CFG);
                OFF_IP_CFG: ipCfg_next = strbWrite(ipCfg_reg, pwdata, pstrb, MASK_IP_CFG);
                OFF_ADDR_CFG: addrCfg_next = strbWrite(addrCfg_reg, pwdata, pstrb, MASK_ADDR_CFG);
                OFF_SRC_ADDR: srcAddr_next = strbWrite(srcAddr_reg, pwdata, pstrb, '1);
                OFF_SRC_MASK: srcMask_next = strbWrite(srcMask_reg, pwdata, pstrb, '1);
                OFF_DST_ADDR: dstAddr_next = strbWrite(dstAddr_reg, pwdata, pstrb, '1);
                OFF_DST_MASK: dstMask_next = strbWrite(dstMask_reg, pwdata, pstrb, '1);
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    // Configuration registers; all criteria reset to don't-care, entry disabled
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= RST_ZERO;
            arpCfg_reg <= RST_ZERO;
            ipCfg_reg <= RST_ZERO;
            addrCfg_reg <= RST_ZERO;
            srcAddr_reg <= RST_ZERO;
            srcMask_reg <= RST_ZERO;
            dstAddr_reg <= RST_ZERO;
            dstMask_reg <= RST_ZERO;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            arpCfg_reg <= arpCfg_next;
            ipCfg_reg <= ipCfg_next;
            addrCfg_reg <= addrCfg_next;
            srcAddr_reg <= srcAddr_next;
            srcMask_reg <= srcMask_next;
            dstAddr_reg <= dstAddr_next;
            dstMask_reg <= dstMask_next;
        end
    end

    // Match result and counters; a counter write clears it unless a frame counts that cycle
    always_comb
    begin
        hitValid_next = frameValid;
        entryHit_next = frameValid && ctrl_reg[0] && allOk;
        lastCrit_next = frameValid ? critAll : lastCrit_reg;
        hitCount_next = hitCount_reg;
        frameCount_next = frameCount_reg;
        if (commitNow && pwrite && regAddr == OFF_HIT_COUNT)
        begin
            hitCount_next = RST_ZERO;
        end
        if (commitNow && pwrite && regAddr == OFF_FRAME_COUNT)
        begin
            frameCount_next = RST_ZERO;
        end
        if (entryHit_next)
        begin
            hitCount_next = hitCount_reg + 32'h0000_0001;
        end
        if (frameValid)
        begin
            frameCount_next = frameCount_reg + 32'h0000_0001;
        end
    end

    // Result and counter registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            hitValid_reg <= 1'b0;
            entryHit_reg <= 1'b0;
            lastCrit_reg <= '0;
            hitCount_reg <= RST_ZERO;
            frameCount_reg <= RST_ZERO;
        end
        else
        begin
            hitValid_reg <= hitValid_next;
            entryHit_reg <= entryHit_next;
            lastCrit_reg <= lastCrit_next;
            hitCount_reg <= hitCount_next;
            frameCount_reg <= frameCount_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign hitValid = hitValid_reg;
    assign entryHit = entryHit_reg;
endmodule : acl_frame_header_matcher

// ---- acl_matcher_props.sv ----
// Port timing checks for the access rule entry matcher
`timescale 1ns/1ps
module acl_matcher_props
    import acl_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frameValid,
    input wire logic hitValid,
    input wire logic entryHit
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // First access cycle of a transfer, and the single-cycle answer
    sequence accessStart;
        psel && $rose(penable);
    endsequence
    sequence answerPulse;
        pready ##1 !pready;
    endsequence
    a_ready_one_wait: assert property (accessStart |=> answerPulse)
        else $error("pready not one pulse a cycle after access");
    a_status_write_err: assert property (accessStart ##0 (pwrite && paddr == OFF_STATUS) |=> pslverr)
        else $error("status write not refused");
    a_unmapped_err: assert property (accessStart ##0 (paddr >= 8'h2C) |=> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_ready_needs_req: assert property (pready |-> $past(psel && penable))
        else $error("pready without a request");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata nonzero outside answer");
    a_hit_follows_frame: assert property (frameValid |=> hitValid)
        else $error("no result a cycle after frame");
    a_hit_needs_frame: assert property (hitValid |-> $past(frameValid))
        else $error("result without a frame");
    a_hit_qualified: assert property (entryHit |-> hitValid)
        else $error("entryHit outside result cycle");
endmodule : acl_matcher_props

// ---- ingress_frame_model.sv ----
// Ingress pipeline stand-in that presents one frame header per call
`timescale 1ns/1ps
module ingress_frame_model
(
    input wire logic sys_clk,
    output logic frameValid,
    output logic frameIsIpv4,
    output logic frameIsArp,
    output logic [7:0] arpHwLen,
    output logic [7:0] arpProtoLen,
    output logic [15:0] arpHwType,
    output logic [15:0] arpProtoType,
    output logic [7:0] ipProto,
    output logic [7:0] ipTtl,
    output logic moreFragments,
    output logic [12:0] fragmentPosition,
    output logic ipOptions,
    output logic [31:0] srcIp,
    output logic [31:0] dstIp
);
    logic [144:0] hdr = '0;
    // Between frames the fields show the inverse of the last header
    assign {frameIsIpv4, frameIsArp, arpHwLen, arpProtoLen, arpHwType, arpProtoType, ipProto,
        ipTtl, moreFragments, fragmentPosition, ipOptions, srcIp, dstIp} = hdr;
    initial frameValid = 1'b0;
    task automatic send(input logic [144:0] h);
        frameValid <= 1'b1;
        hdr <= h;
        @(posedge sys_clk);
        frameValid <= 1'b0;
        hdr <= ~h;
    endtask : send
endmodule : ingress_frame_model

// ---- acl_frame_header_matcher_tb.sv ----
// Self-checking bench for the access rule entry matcher
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errTotal++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acl_frame_header_matcher_tb
    import acl_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, srcIp, dstIp;
    logic pready, pslverr, hitValid, entryHit, frameValid, frameIsIpv4, frameIsArp;
    logic moreFragments, ipOptions;
    logic [7:0] arpHwLen, arpProtoLen, ipProto, ipTtl;
    logic [15:0] arpHwType, arpProtoType;
    logic [12:0] fragmentPosition;
    // Header of the next frame to send
    logic isIp, isA, mf, opt;
    logic [7:0] hLen, pLen, pro, ttl;
    logic [15:0] hType, pType;
    logic [12:0] fpos;
    logic [31:0] source_ipv4_filter, destination_ipv4_filter;
    logic [2:0] sels [3] = '{PSEL_ICMP, PSEL_UDP, PSEL_TCP};
    logic [7:0] nums [3] = '{8'h01, 8'h11, 8'h06};
    int errTotal = 0;
    int testsRun = 0;

    always #5 sys_clk = ~sys_clk;

    acl_frame_header_matcher acl_frame_header_matcher_i (.sys_clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .frameValid, .frameIsIpv4,
        .frameIsArp, .arpHwLen, .arpProtoLen, .arpHwType, .arpProtoType, .ipProto, .ipTtl,
        .moreFragments, .fragmentPosition, .ipOptions, .srcIp, .dstIp, .hitValid, .entryHit);
    ingress_frame_model ingress_frame_model_i (.sys_clk, .frameValid, .frameIsIpv4, .frameIsArp,
        .arpHwLen, .arpProtoLen, .arpHwType, .arpProtoType, .ipProto, .ipTtl, .moreFragments,
        .fragmentPosition, .ipOptions, .srcIp, .dstIp);

    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : completeRun

    // One APB transfer; exp holds the expected error flag and read data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [32:0] exp);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // Wait for the answer; only the watchdog ends a hung transfer
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        `CHK({pslverr, prdata}, exp)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc

    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hF, 33'h0);
    endtask : cfg

    function automatic logic [31:0] fld(input logic [2:0] v, input int lsb);
        return 32'(v) << lsb;
    endfunction : fld

    task automatic ipF();
        {isIp, isA, pro, ttl, mf, fpos, opt} = {2'b10, 8'h06, 8'h40, 1'b0, 13'h0, 1'b0};
        {source_ipv4_filter, destination_ipv4_filter} = {32'hC0A8_0A05, 32'hC0A8_0A05};
    endtask : ipF

    task automatic arpF();
        {isIp, isA, hLen, pLen, hType, pType} = {2'b01, 8'h06, 8'h04, 16'h0001, 16'h0800};
    endtask : arpF

    // Send the current header and check the result one cycle later
    task automatic hit(input logic exp);
        @(posedge sys_clk);
        ingress_frame_model_i.send({isIp, isA, hLen, pLen, hType, pType, pro, ttl, mf, fpos,
            opt, source_ipv4_filter, destination_ipv4_filter});
        #1;
        `CHK({hitValid, entryHit}, {1'b1, exp})
    endtask : hit

    // Make the criterion's condition true or false on a fresh frame
    task automatic setCond(input int k, input logic c);
        if (k < 4)
            ipF();
        else
            arpF();
        case (k)
            0: ttl = c ? 8'h01 : 8'h00;
            1: mf = c;
            2: fpos = c ? 13'h0001 : 13'h0000;
            3: opt = c;
            4: hLen = c ? 8'h06 : 8'h07;
            5: pLen = c ? 8'h04 : 8'h05;
            6: hType = c ? 16'h0001 : 16'h0006;
            default: pType = c ? 16'h0800 : 16'h0806;
        endcase
    endtask : setCond

    // Walk a three-way criterion through false, true and any settings
    task automatic triRun(input int k, input int lsb);
        logic [1:0] s;
        for (int i = 0; i < 3; i++)
        begin
            s = (i == 0) ? TRI_FALSE : (i == 1) ? TRI_TRUE : TRI_ANY;
            cfg((k < 4) ? OFF_IP_CFG : OFF_ARP_CFG, fld({1'b0, s}, lsb));
            setCond(k, 1'b1);
            hit(s != TRI_FALSE);
            setCond(k, 1'b0);
            hit(s != TRI_TRUE);
            setCond(7 - k, 1'b1);
            hit(s == TRI_ANY);
        end
    endtask : triRun

    task automatic setAddr(input logic dst, input logic [31:0] v);
        ipF();
        if (dst)
            destination_ipv4_filter = v;
        else
            source_ipv4_filter = v;
    endtask : setAddr

    // Host, network and any modes of one address filter
    task automatic addrRun(input logic dst, input int lsb);
        cfg(dst ? OFF_DST_ADDR : OFF_SRC_ADDR, 32'hC0A8_0A05);
        cfg(dst ? OFF_DST_MASK : OFF_SRC_MASK, 32'hFFFF_FF00);
        cfg(OFF_ADDR_CFG, fld({1'b0, AMODE_HOST}, lsb));
        setAddr(dst, 32'hC0A8_0A05);
        hit(1'b1);
        setAddr(dst, 32'hC0A8_0A04);
        hit(1'b0);
        cfg(OFF_ADDR_CFG, fld({1'b0, AMODE_NET}, lsb));
        hit(1'b1);
        setAddr(dst, 32'hC0A8_0B05);
        hit(1'b0);
        arpF();
        hit(1'b0);
        cfg(OFF_ADDR_CFG, 32'h0000_0000);
        setAddr(dst, 32'h0102_0304);
        hit(1'b1);
    endtask : addrRun

    initial
    begin
        ipF();
        arpF();
        ipF();
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        acc(1'b0, OFF_CTRL, 32'h0, 4'hF, 33'h0);
        acc(1'b0, OFF_IP_CFG, 32'h0, 4'hF, 33'h0);
        acc(1'b0, 8'h30, 32'h0, 4'hF, {1'b1, 32'h0});
        acc(1'b1, OFF_STATUS, 32'hFFFF_FFFF, 4'hF, {1'b1, 32'h0});
        hit(1'b0);
        cfg(OFF_CTRL, 32'h0000_0001);
        hit(1'b1);
        triRun(0, IP_TTL_LSB);
        triRun(1, IP_FRAG_LSB);
        triRun(2, IP_FRAG_LSB);
        triRun(3, IP_OPT_LSB);
        triRun(4, ARP_LEN_LSB);
        triRun(5, ARP_LEN_LSB);
        triRun(6, ARP_HW_LSB);
        triRun(7, ARP_PRO_LSB);
        for (int i = 0; i < 3; i++)
        begin
            cfg(OFF_IP_CFG, {29'h0, sels[i]});
            ipF();
            pro = nums[i];
            hit(1'b1);
            pro = nums[i] + 8'h01;
            hit(1'b0);
        end
        cfg(OFF_IP_CFG, 32'h0000_FF01);
        pro = 8'hFF;
        hit(1'b1);
        pro = 8'hFE;
        hit(1'b0);
        acc(1'b1, OFF_IP_CFG, 32'h0000_0000, 4'h2, 33'h0);
        acc(1'b0, OFF_IP_CFG, 32'h0, 4'hF, 33'h0_0000_0001);
        pro = 8'h00;
        hit(1'b1);
        arpF();
        hit(1'b0);
        cfg(OFF_IP_CFG, 32'h0000_0000);
        addrRun(1'b0, SRC_MODE_LSB);
        addrRun(1'b1, DST_MODE_LSB);
        // Clear both counters, send one hitting frame, expect one of each
        cfg(OFF_HIT_COUNT, 32'h0000_0000);
        cfg(OFF_FRAME_COUNT, 32'h0000_0000);
        hit(1'b1);
        acc(1'b0, OFF_HIT_COUNT, 32'h0, 4'hF, 33'h0_0000_0001);
        acc(1'b0, OFF_FRAME_COUNT, 32'h0, 4'hF, 33'h0_0000_0001);
        completeRun();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #100000;
        errTotal++;
        completeRun();
    end
endmodule : acl_frame_header_matcher_tb

bind acl_frame_header_matcher acl_matcher_props #(.ADDR_W(ADDR_W)) props_i (.sys_clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .frameValid, .hitValid,
    .entryHit);
